// *** design/ptd_pulse_core.v ***
// Pulse status, per-axis threshold and time-limit logic behind the sensor's register port
`timescale 1ns/10ps
`include "ptd_defines.vh"

module ptd_pulse_core #(
    parameter integer CLK_HZ = 50000000,
    parameter integer UNIT_US = `PTD_STEP_UNIT_US
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [47:0] i_accel_xyz,
    input wire i_accel_valid,
    input wire [2:0] i_output_rate,
    input wire [1:0] i_power_mode,
    input wire i_hpf_enable,
    input wire i_hybrid_mode,
    input wire i_latch_enable,
    input wire [5:0] i_event_enable,
    input wire i_double_pulse,
    output reg [7:0] o_reg_rdata,
    output reg o_event_active
);
    // Cycles per 0.625 ms unit: clock cycles per microsecond times unit length in microseconds
    localparam integer UNIT_CYCLES = (CLK_HZ / 1000000) * UNIT_US;

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] status_q;
    reg [7:0] ths_x_q;
    reg [7:0] ths_y_q;
    reg [7:0] ths_z_q;
    reg [7:0] tmlt_q;
    reg [2:0] above_q;
    reg [2:0] sign_q;
    reg [7:0] dur_q [0:2];
    reg [2:0] done_q;
    reg [2:0] ok_q;
    wire tick;
    wire status_rd;
    reg [9:0] units;
    reg [7:0] status_d;
    integer a;
    integer b;

    // Magnitude of a 16-bit sample on the 8 g scale in 0.063 g counts
    function [7:0] ptd_mag;
        input [15:0] s;
        reg [15:0] m;
        begin
            m = s[15] ? (~s + 16'h0001) : s;
            ptd_mag = m[15:8];
        end
    endfunction

    function [7:0] ptd_ths;
        input [1:0] ax;
        begin
            case (ax)
                2'h0: ptd_ths = {1'b0, ths_x_q[6:0]};
                2'h1: ptd_ths = {1'b0, ths_y_q[6:0]};
                default: ptd_ths = {1'b0, ths_z_q[6:0]};
            endcase
        end
    endfunction

    // ****************************************
    // Step size
    // ****************************************
    always @* begin
        if (i_hpf_enable) begin
            // Base step with filter on, in 0.625 ms units
            case (i_output_rate)
                3'h0: units = 10'h002;
                3'h1: units = 10'h004;
                3'h2: units = 10'h008;
                3'h3: units = 10'h010;
                default: units = 10'h020;
            endcase
            if (i_power_mode == `PTD_MODE_HIRES && i_output_rate != `PTD_ODR_800) begin
                units = 10'h004;
            end else if (i_output_rate > `PTD_ODR_50) begin
                if (i_power_mode == `PTD_MODE_LOW_POWER_LOW_NOISE_MODE) begin
                    units = 10'h080;
                end else if (i_power_mode == `PTD_MODE_LP) begin
                    units = (i_output_rate == 3'h5) ? 10'h080 : 10'h100;
                end
            end
        end else begin
            // Filter off has its own table; a plain halving would be too long below 800 Hz
            case (i_output_rate)
                3'h0: units = 10'h001;
                3'h1: units = 10'h001;
                3'h2: units = 10'h002;
                3'h3: units = 10'h004;
                default: units = 10'h008;
            endcase
            if (i_power_mode == `PTD_MODE_HIRES) begin
                units = 10'h001;
            end else if (i_power_mode == `PTD_MODE_LP) begin
                if (i_output_rate > `PTD_ODR_50) begin
                    units = 10'h040;
                end else if (i_output_rate != `PTD_ODR_800) begin
                    units = units << 1;
                end
            end else if (i_power_mode == `PTD_MODE_LOW_POWER_LOW_NOISE_MODE && i_output_rate > `PTD_ODR_50) begin
                units = 10'h020;
            end
        end
        if (i_hybrid_mode) begin
            units = units << 1;
        end
    end

    ptd_step_timer #(
        .CLK_HZ(CLK_HZ),
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_restart(1'b0),
        .i_units(units),
        .o_tick(tick)
    );

    assign status_rd = i_reg_rd && i_reg_addr == `PTD_ADDR_STATUS;

    // ****************************************
    // Detection and status
    // ****************************************
    always @* begin
        status_d = status_q;
        if (status_rd || !i_latch_enable) begin
            status_d = `PTD_RST_STATUS;
        end
        for (a = 0; a < 3; a = a + 1) begin
            if (ok_q[a] && (i_event_enable[2 * a] || i_event_enable[2 * a + 1])) begin
                status_d[`PTD_ST_AXX + a] = 1'b1;
                status_d[`PTD_ST_POLX + a] = sign_q[a];
                status_d[`PTD_ST_DPE] = i_double_pulse;
                status_d[`PTD_ST_EA] = 1'b1;
            end
        end
        if (!i_latch_enable && !(|ok_q)) begin
            status_d = status_q;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            status_q <= `PTD_RST_STATUS;
            ths_x_q <= `PTD_RST_THS;
            ths_y_q <= `PTD_RST_THS;
            ths_z_q <= `PTD_RST_THS;
            tmlt_q <= `PTD_RST_TMLT;
            above_q <= 3'h0;
            sign_q <= 3'h0;
            done_q <= 3'h0;
            ok_q <= 3'h0;
            dur_q[0] <= 8'h00;
            dur_q[1] <= 8'h00;
            dur_q[2] <= 8'h00;
            o_reg_rdata <= 8'h00;
            o_event_active <= 1'b0;
        end else if (i_ce) begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `PTD_ADDR_THS_X: ths_x_q <= {1'b0, i_reg_wdata[6:0]};
                    `PTD_ADDR_THS_Y: ths_y_q <= {1'b0, i_reg_wdata[6:0]};
                    `PTD_ADDR_THS_Z: ths_z_q <= {1'b0, i_reg_wdata[6:0]};
                    `PTD_ADDR_TMLT: tmlt_q <= i_reg_wdata;
                    default: ;
                endcase
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `PTD_ADDR_STATUS: o_reg_rdata <= status_q;
                    `PTD_ADDR_THS_X: o_reg_rdata <= ths_x_q;
                    `PTD_ADDR_THS_Y: o_reg_rdata <= ths_y_q;
                    `PTD_ADDR_THS_Z: o_reg_rdata <= ths_z_q;
                    `PTD_ADDR_TMLT: o_reg_rdata <= tmlt_q;
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
            ok_q <= 3'h0;
            for (b = 0; b < 3; b = b + 1) begin
                // Fixed 8 g scale: data scale setting never reaches here
                if (i_accel_valid) begin
                    if (ptd_mag(i_accel_xyz[16 * b +: 16]) > ptd_ths(b[1:0])) begin
                        if (!above_q[b]) begin
                            above_q[b] <= 1'b1;
                            sign_q[b] <= i_accel_xyz[16 * b + 15];
                            dur_q[b] <= 8'h00;
                            done_q[b] <= 1'b0;
                        end
                    end else if (above_q[b]) begin
                        above_q[b] <= 1'b0;
                        ok_q[b] <= !done_q[b];
                    end
                end
                if (tick && above_q[b] && !done_q[b]) begin
                    // Pulse too long once the count passes the limit
                    if (dur_q[b] >= tmlt_q) begin
                        done_q[b] <= 1'b1;
                    end else begin
                        dur_q[b] <= dur_q[b] + 8'h01;
                    end
                end
            end
            status_q <= status_d;
            o_event_active <= status_d[`PTD_ST_EA];
        end
    end
endmodule // ptd_pulse_core

// *** design/ptd_defines.vh ***
// Register offsets, field positions, reset values, rate and mode codes and the step unit for the pulse status/threshold/time-limit block
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define PTD_ADDR_STATUS 8'h22
`define PTD_ADDR_THS_X 8'h23
`define PTD_ADDR_THS_Y 8'h24
`define PTD_ADDR_THS_Z 8'h25
`define PTD_ADDR_TMLT 8'h26

// ****************************************
// Status field positions
// ****************************************
`define PTD_ST_EA 7
`define PTD_ST_AXZ 6
`define PTD_ST_AXY 5
`define PTD_ST_AXX 4
`define PTD_ST_DPE 3
`define PTD_ST_POLZ 2
`define PTD_ST_POLY 1
`define PTD_ST_POLX 0

// ****************************************
// Reset values
// ****************************************
`define PTD_RST_STATUS 8'h00
`define PTD_RST_THS 8'h00
`define PTD_RST_TMLT 8'h00

// ****************************************
// Output rate codes (800,400,200,100,50,12.5,6.25,1.56 Hz)
// ****************************************
`define PTD_ODR_800 3'h0
`define PTD_ODR_400 3'h1
`define PTD_ODR_50 3'h4

// ****************************************
// Power modes
// ****************************************
`define PTD_MODE_NORMAL 2'h0
`define PTD_MODE_LOW_POWER_LOW_NOISE_MODE 2'h1
`define PTD_MODE_HIRES 2'h2
`define PTD_MODE_LP 2'h3

// ****************************************
// Time limit step in units of 0.625 ms (1 unit = filter off at 800 Hz)
// ****************************************
`define PTD_STEP_UNIT_US 625
`define PTD_TMLT_MAX 8'hFF
`define PTD_THS_LSB_MILLI_G 63
`define PTD_FULL_SCALE_G 8

`endif

// *** design/ptd_step_timer.v ***
// Step timer: produces one tick per time-limit step from clock-cycle counting
`timescale 1ns/10ps
module ptd_step_timer #(
    parameter integer CLK_HZ = 50000000,
    parameter integer UNIT_CYCLES = 31250
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_restart,
    input wire [9:0] i_units,
    output reg o_tick
);
    reg [24:0] cnt_q;
    wire [24:0] span;

    // Step length in cycles = units of 0.625 ms times cycles per unit
    assign span = i_units * UNIT_CYCLES[14:0];

    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 25'h0000000;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            o_tick <= 1'b0;
            if (i_restart) begin
                cnt_q <= 25'h0000000;
            end else if (cnt_q + 25'h0000001 >= span) begin
                cnt_q <= 25'h0000000;
                o_tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 25'h0000001;
            end
        end
    end
endmodule // ptd_step_timer

// *** test/ptd_host.sv ***
// Host model driving the register port with one-cycle strobes
`timescale 1ns/10ps
module ptd_host (
    input wire logic i_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_ce,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_ce = 1'b1;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // Stale data is inverted on release so a late sample cannot pass by luck
    // One idle edge follows so a next strobe is never set in the release time step
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d;
        @(posedge i_clk);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk);
        o_reg_rd <= 1'b0;
        @(posedge i_clk);
        d = i_reg_rdata;
    endtask
endmodule // ptd_host

// *** test/ptd_pulse_core_checker.sv ***
// Port-level assertions for the pulse status and threshold registers
`timescale 1ns/10ps
module ptd_pulse_core_checker (
    input logic i_clk,
    input logic i_rst,
    input logic i_ce,
    input logic i_reg_wr,
    input logic i_reg_rd,
    input logic [7:0] i_reg_addr,
    input logic [7:0] i_reg_wdata,
    input logic i_accel_valid,
    input logic i_latch_enable,
    input logic [5:0] i_event_enable,
    input logic [7:0] o_reg_rdata,
    input logic o_event_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire rd_ok = i_ce && i_reg_rd;
    a_reset_zero: assert property (disable iff (1'b0) i_rst |=> o_reg_rdata == 8'h00 && !o_event_active)
        else $error("reset did not clear outputs");
    a_ths_msb_zero: assert property (rd_ok && i_reg_addr inside {8'h23, 8'h24, 8'h25} |=> !o_reg_rdata[7])
        else $error("threshold bit 7 read as one");
    a_unmapped_zero: assert property (rd_ok && (i_reg_addr < 8'h22 || i_reg_addr > 8'h26) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!rd_ok |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
    a_ths_readback: assert property (i_ce && i_reg_wr && i_reg_addr == 8'h23 ##1 !i_reg_wr
        ##1 rd_ok && !i_reg_wr && i_reg_addr == 8'h23 |=> o_reg_rdata == {1'b0, $past(i_reg_wdata[6:0], 3)})
        else $error("threshold readback wrong");
    a_ea_axes: assert property (rd_ok && i_reg_addr == 8'h22 |=> o_reg_rdata[7] == |o_reg_rdata[6:4])
        else $error("event flag disagrees with axis flags");
    a_no_enable: assert property (i_event_enable == 6'h00 && !o_event_active |=> !o_event_active)
        else $error("event flag rose with all events disabled");
    a_latch_clear: assert property (i_ce && !i_accel_valid ##1 i_latch_enable && rd_ok && i_reg_addr == 8'h22
        && !i_accel_valid ##1 !i_accel_valid |=> !o_event_active)
        else $error("status read did not clear latched flag");
endmodule // ptd_pulse_core_checker
bind ptd_pulse_core ptd_pulse_core_checker u_ptd_pulse_core_checker (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_accel_valid(i_accel_valid), .i_latch_enable(i_latch_enable), .i_event_enable(i_event_enable),
    .o_reg_rdata(o_reg_rdata), .o_event_active(o_event_active));

// *** test/test_ptd_pulse_core.sv ***
// Self-checking bench for the pulse status, threshold and time-limit registers
`timescale 1ns/10ps
module test_ptd_pulse_core;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_accel_valid = 1'b0;
    logic i_double_pulse = 1'b0;
    logic [5:0] i_event_enable = 6'h00;
    logic [47:0] i_accel_xyz = 48'h0;
    logic [2:0] i_output_rate = 3'h0;
    logic [1:0] i_power_mode = 2'h0;
    logic i_hpf_enable = 1'b1;
    logic i_hybrid_mode = 1'b0;
    logic i_latch_enable = 1'b1;
    logic i_ce, i_reg_wr, i_reg_rd, o_event_active;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    always #10 i_clk = ~i_clk;
    ptd_host u_ptd_host (.i_clk(i_clk), .i_reg_rdata(o_reg_rdata), .o_ce(i_ce), .o_reg_wr(i_reg_wr),
        .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
    // One clock per 0.625 ms unit, so a step of N units is exactly N cycles
    ptd_pulse_core #(.CLK_HZ(1000000), .UNIT_US(1)) u_ptd_pulse_core (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_accel_xyz(i_accel_xyz), .i_accel_valid(i_accel_valid), .i_output_rate(i_output_rate),
        .i_power_mode(i_power_mode), .i_hpf_enable(i_hpf_enable), .i_hybrid_mode(i_hybrid_mode),
        .i_latch_enable(i_latch_enable), .i_event_enable(i_event_enable),
        .i_double_pulse(i_double_pulse), .o_reg_rdata(o_reg_rdata), .o_event_active(o_event_active));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_ptd_host.read_reg(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask
    // One sample above or below threshold, n - 1 counted edges, then a quiet sample that ends the pulse
    task automatic pulse(input logic [47:0] v, input int n);
        i_accel_xyz <= v;
        i_accel_valid <= 1'b1;
        @(posedge i_clk);
        i_accel_valid <= 1'b0;
        repeat (n - 1) @(posedge i_clk);
        i_accel_xyz <= 48'h0;
        i_accel_valid <= 1'b1;
        @(posedge i_clk);
        i_accel_valid <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // Step inputs and limit set, then an X pulse over 12 counted edges: it qualifies if 12 / step <= limit
    task automatic tml(input logic [2:0] r, input logic [1:0] m, input logic h, input logic y,
        input logic [7:0] t, input logic [7:0] e);
        i_output_rate <= r;
        i_power_mode <= m;
        i_hpf_enable <= h;
        i_hybrid_mode <= y;
        u_ptd_host.write_reg(8'h26, t);
        pulse(48'h2000, 13);
        rdchk(8'h22, e);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 8'h22; a <= 8'h26; a++) rdchk(a[7:0], 8'h00);
        $display("test reset done");
        for (int a = 8'h23; a <= 8'h25; a++) begin
            u_ptd_host.write_reg(a[7:0], 8'hFF);
            rdchk(a[7:0], 8'h7F);
        end
        u_ptd_host.write_reg(8'h26, 8'hFF);
        rdchk(8'h26, 8'hFF);
        u_ptd_host.write_reg(8'h22, 8'h5A);
        rdchk(8'h22, 8'h00);
        rdchk(8'h30, 8'h00);
        $display("test access done");
        for (int a = 8'h23; a <= 8'h25; a++) u_ptd_host.write_reg(a[7:0], 8'h10);
        i_event_enable <= 6'h01;
        pulse(48'h1000, 5);
        rdchk(8'h22, 8'h00);
        for (int a = 0; a < 3; a++) begin
            i_event_enable <= 6'h01 << (2 * a);
            pulse(48'hE000 << (16 * a), 5);
            chk("event flag", {7'h00, o_event_active}, 8'h01);
            rdchk(8'h22, 8'h80 | (8'h10 << a) | (8'h01 << a));
            rdchk(8'h22, 8'h00);
        end
        i_event_enable <= 6'h02;
        i_double_pulse <= 1'b1;
        pulse(48'h2000, 5);
        rdchk(8'h22, 8'h98);
        i_event_enable <= 6'h00;
        i_double_pulse <= 1'b0;
        pulse(48'h2000, 5);
        rdchk(8'h22, 8'h00);
        $display("test events done");
        i_event_enable <= 6'h01;
        tml(3'h1, 2'h0, 1'b1, 1'b0, 8'h04, 8'h90);
        tml(3'h0, 2'h0, 1'b1, 1'b0, 8'h04, 8'h00);
        tml(3'h0, 2'h0, 1'b1, 1'b1, 8'h04, 8'h90);
        tml(3'h1, 2'h0, 1'b0, 1'b0, 8'h08, 8'h00);
        tml(3'h3, 2'h0, 1'b0, 1'b0, 8'h04, 8'h90);
        tml(3'h3, 2'h2, 1'b1, 1'b0, 8'h02, 8'h00);
        tml(3'h3, 2'h0, 1'b1, 1'b0, 8'h02, 8'h90);
        $display("test time limit done");
        i_latch_enable <= 1'b0;
        pulse(48'h2000, 5);
        rdchk(8'h22, 8'h90);
        rdchk(8'h22, 8'h90);
        i_latch_enable <= 1'b1;
        rdchk(8'h22, 8'h90);
        rdchk(8'h22, 8'h00);
        $display("test latch done");
        summarize();
    end
endmodule // test_ptd_pulse_core
